/* rtl/icl_pkg.sv */
// constants and types for the interrupt cascade logic
// assumes a single 125 MHz clock domain
package icl_pkg;
  localparam int          ICL_GROUPS      = 8;
  localparam int          ICL_GRP_W       = 3;
  localparam logic [1:0]  ICL_MODE_SLAVE  = 2'h0;
  localparam logic [1:0]  ICL_MODE_DAISY  = 2'h1;
  localparam logic [1:0]  ICL_ADDR_RESET  = 2'h0;
  localparam logic [4:0]  ICL_VEC_BASE_RST = 5'h00;
  localparam logic        ICL_ACK_ONE     = 1'h0;
  localparam logic        ICL_ACK_TWO     = 1'h1;

  typedef enum logic [2:0]
  {
    ICL_IDLE  = 3'h1,
    ICL_FIRST = 3'h2,
    ICL_HOLD  = 3'h4
  } icl_state_t;
endpackage

/* rtl/icl_prio_enc.sv */
// fixed priority encoder over the interrupt groups, group 0 highest
// assumes pending bits are synchronous to the clock
`timescale 1ns/100ps
`default_nettype none
module icl_prio_enc
  import icl_pkg::*;
(
  input  wire logic [ICL_GROUPS-1:0] pending,
  output logic                       anyPending,
  output logic [ICL_GRP_W-1:0]       topGroup
);
  logic [ICL_GRP_W-1:0] sel [ICL_GROUPS:0];

  assign sel[ICL_GROUPS] = '0;
  genvar g;
  generate
    for (g = 0; g < ICL_GROUPS; g++)
    begin : g_prio
      assign sel[g] = pending[g] ? ICL_GRP_W'(g) : sel[g+1];
    end
  endgenerate

  assign topGroup   = sel[0];
  assign anyPending = |pending;
endmodule
`default_nettype wire

/* rtl/icl_cascade.sv */
// interrupt request and acknowledge cascading for slave and daisy-chain modes
// assumes all pins synchronous to sys_clk; mode and slave address held
// stable by software while interrupts are enabled
//
// Overview of operation
// - slave mode: both chain enable pins are inputs, none driven
// - slave mode: acknowledge taken only with request raised and address match
// - daisy mode: drive downstream enable, sample upstream enable
// - daisy mode: low upstream enable clears downstream output at once
// - daisy mode: low upstream enable blocks and withdraws interrupt request
// - outside acknowledge, high upstream enable permits raising request
// - raising request in daisy mode drives downstream output low at once
// - daisy mode: acknowledge taken only with request raised and upstream high
// - no new interrupt from acknowledge until end of second acknowledge
// - daisy mode: downstream output returns high when request cleared and upstream high
// - accepted acknowledge outputs vector of highest priority active group
// - single-cycle mode clears request at next valid acknowledge end
`timescale 1ns/100ps
`default_nettype none
module icl_cascade
  import icl_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic [ICL_GROUPS-1:0] groupPending,
  input  wire logic [1:0]            cascadeMode,
  input  wire logic [1:0]            slaveAddr,
  input  wire logic                  ackMode,
  input  wire logic [4:0]            vectorBase,
  input  wire logic                  irqAckLine_n,
  input  wire logic                  chainEnableOutIn,
  input  wire logic                  chainEnableIn,
  output logic                       chainEnableOut,
  output logic                       chainEnableOutOe,
  output logic                       irqReq,
  output logic [7:0]                 vectorData,
  output logic                       vectorOe
);
  ////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rstMeta_q;
  logic rstSync_q;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rstSyncN = rstSync_q;

  ////////////////////////////////////////////////////////////////////
  // decode
  logic                 anyPending;
  logic [ICL_GRP_W-1:0] topGroup;
  icl_prio_enc u_prio
  (
    .pending    (groupPending),
    .anyPending (anyPending),
    .topGroup   (topGroup)
  );

  wire daisyMode  = (cascadeMode == ICL_MODE_DAISY);
  wire slaveMode  = !daisyMode;
  // in slave mode both chain pins carry the address
  wire [1:0] pinAddr = {chainEnableIn, chainEnableOutIn};
  wire upstreamOk = slaveMode || chainEnableIn;

  icl_state_t state_q;
  icl_state_t state_d;
  logic       irq_q;
  logic       irq_d;
  logic       ackDly_q;

  wire ackActive = !irqAckLine_n;
  // rising edge of the acknowledge strobe ends a cycle
  wire ackEnd    = ackDly_q && irqAckLine_n;
  wire addrMatch = (pinAddr == slaveAddr);
  wire ackTaken  = ackActive && irq_q && (daisyMode ? chainEnableIn : addrMatch);
  wire inService = (state_q != ICL_IDLE);
  logic acceptSeen_q;

  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      ackDly_q <= 1'b0;
    else
      ackDly_q <= ackActive;
  end

  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      acceptSeen_q <= 1'b0;
    else if (ackTaken)
      acceptSeen_q <= 1'b1;
    else if (ackEnd)
      acceptSeen_q <= 1'b0;
  end
  wire validEnd = ackEnd && acceptSeen_q;

  ////////////////////////////////////////////////////////////////////
  // acknowledge sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ICL_IDLE:
        if (validEnd)
          state_d = (ackMode == ICL_ACK_TWO) ? ICL_FIRST : ICL_IDLE;
      ICL_FIRST:
        if (validEnd)
          state_d = ICL_IDLE;
      default:
        state_d = ICL_IDLE;
    endcase
  end

  // request clears at end of the last acknowledge of the pair
  wire lastEnd = validEnd && ((ackMode == ICL_ACK_ONE) || (state_q == ICL_FIRST));

  always_comb
  begin
    irq_d = irq_q;
    if (!upstreamOk)
      irq_d = 1'b0;
    else if (lastEnd)
      irq_d = 1'b0;
    else if (!irq_q && anyPending && !ackActive && !inService && !acceptSeen_q)
      irq_d = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_q <= ICL_IDLE;
      irq_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      irq_q   <= irq_d;
    end
  end

  // pending sources left after the clear raise a fresh request next cycle
  assign irqReq = irq_q && upstreamOk;

  ////////////////////////////////////////////////////////////////////
  // chain output: combinational so blocking needs no clock edge
  assign chainEnableOutOe = daisyMode;
  assign chainEnableOut   = daisyMode && chainEnableIn && !irq_q;

  ////////////////////////////////////////////////////////////////////
  // vector output
  logic [7:0] vec_q;
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      vec_q <= {ICL_VEC_BASE_RST, 3'h0};
    else if (ackTaken && !acceptSeen_q)
      vec_q <= {vectorBase, topGroup};
  end
  assign vectorData = vec_q;
  assign vectorOe   = acceptSeen_q && ackActive;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_slave_nodrive: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    slaveMode |-> !chainEnableOutOe) else $error("chain out driven in slave mode");
  a_slave_accept: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (slaveMode && ackTaken) |-> (irq_q && pinAddr == slaveAddr))
    else $error("slave ack without match");
  a_daisy_drive: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    daisyMode |-> chainEnableOutOe) else $error("chain out not driven in daisy");
  a_upstream_block: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && !chainEnableIn) |-> (!chainEnableOut && !irqReq))
    else $error("low upstream not blocking");
  a_upstream_withdraw: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && !chainEnableIn) |=> !irq_q) else $error("request not withdrawn");
  a_raise_ok: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (!irq_q && anyPending && upstreamOk && !ackActive && !inService && !acceptSeen_q)
    |=> irq_q) else $error("request not raised");
  a_req_blocks: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    irqReq |-> !chainEnableOut) else $error("chain open with request");
  a_daisy_accept: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && ackTaken) |-> (chainEnableIn && irq_q)) else $error("daisy ack bad");
  a_no_new_irq: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (!irq_q && inService) |=> !irq_q) else $error("irq during service");
  a_chain_return: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && !irq_q && chainEnableIn) |-> chainEnableOut)
    else $error("chain not restored");
  a_vector_group: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (ackTaken && !acceptSeen_q) |=> (vectorData[2:0] == $past(topGroup)))
    else $error("wrong vector group");
  a_single_clear: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (validEnd && ackMode == ICL_ACK_ONE) |=> !irq_q) else $error("single clear missed");
  a_double_hold: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (validEnd && ackMode == ICL_ACK_TWO && state_q == ICL_IDLE && upstreamOk) |=> irq_q)
    else $error("cleared after first ack");

  c_slave_ack: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
    slaveMode && ackTaken);
  c_daisy_ack: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
    daisyMode && ackTaken);
  c_two_cycle: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
    state_q == ICL_FIRST && validEnd);
  c_abort: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
    irq_q && daisyMode && !chainEnableIn);
  c_refused: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
    ackActive && !irq_q && !acceptSeen_q);

  ////////////////////////////////////////////////////////////////////
  // acceptance and vector checks
  a_oe_rise_accept: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    $rose(vectorOe) |-> $past(ackTaken))
    else $error("vector enabled without acceptance");

  a_oe_strobe: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    irqAckLine_n |-> !vectorOe)
    else $error("vector driven outside strobe");

  a_vec_stable: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (vectorOe && $past(vectorOe)) |-> $stable(vectorData))
    else $error("vector moved while driven");

  a_vector_base: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (ackTaken && !acceptSeen_q) |=> (vectorData[7:3] == $past(vectorBase)))
    else $error("wrong vector base");

  // independent of the encoder: group 0 always wins
  a_vector_top: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (ackTaken && !acceptSeen_q && groupPending[0]) |=> (vectorData[2:0] == 3'h0))
    else $error("top group not chosen");

  a_vector_low: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (ackTaken && !acceptSeen_q && groupPending == 8'h80) |=> (vectorData[2:0] == 3'h7))
    else $error("lowest group not chosen");

  a_oe_follows: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (ackTaken && !acceptSeen_q) |=> (vectorOe || irqAckLine_n))
    else $error("vector not driven after acceptance");

  a_ack_no_irq: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (ackActive && !irq_q && !acceptSeen_q) |=> !acceptSeen_q)
    else $error("ack taken without request");

  a_slave_mismatch: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (slaveMode && ackActive && !acceptSeen_q && pinAddr != slaveAddr) |=> !acceptSeen_q)
    else $error("ack taken on wrong address");

  a_daisy_refuse: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && ackActive && !acceptSeen_q && !chainEnableIn) |=> !acceptSeen_q)
    else $error("ack taken with upstream low");

  ////////////////////////////////////////////////////////////////////
  // request and chain checks
  a_hold_in_ack: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (!irq_q && ackActive) |=> !irq_q)
    else $error("request raised during strobe");

  a_hold_accepted: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (!irq_q && acceptSeen_q) |=> !irq_q)
    else $error("request raised while accepted");

  a_second_clear: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (validEnd && state_q == ICL_FIRST) |=> !irq_q)
    else $error("second ack did not clear");

  a_first_from_two: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    ($past(state_q) == ICL_IDLE && state_q == ICL_FIRST) |-> ($past(ackMode) == ICL_ACK_TWO))
    else $error("pairing in single mode");

  a_state_onehot: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    $onehot(state_q))
    else $error("sequencer state corrupt");

  a_end_clears_seen: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    ackEnd |=> !acceptSeen_q)
    else $error("acceptance outlived strobe");

  a_slave_out_low: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    slaveMode |-> !chainEnableOut)
    else $error("chain value active in slave mode");

  a_chain_low_now: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && irq_q) |-> !chainEnableOut)
    else $error("chain open with request pending");

  a_req_live: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    irqReq |-> (irq_q && (slaveMode || chainEnableIn)))
    else $error("request shown while blocked");

  a_keep_raised: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (daisyMode && chainEnableIn && irq_q && !ackActive && !acceptSeen_q) |=> irq_q)
    else $error("request dropped with upstream high");
endmodule
`default_nettype wire

/* test/icl_host_model.sv */
// host acknowledge logic facing the cascade block
// assumes callers invoke its tasks just after a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module icl_host_model (
  input  wire logic       sys_clk,
  input  wire logic       vectorOe,
  input  wire logic [7:0] vectorData,
  output var logic        irqAckLine_n
);
  // strobe idles high whenever no acknowledge is running
  initial irqAckLine_n = 1'b1;

  // strobe held low two cycles so the vector has settled before reading
  task automatic ack_start(output logic oe, output logic [7:0] vec);
    irqAckLine_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    oe = vectorOe;
    vec = vectorData;
  endtask

  task automatic ack_end();
    irqAckLine_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the interrupt cascade logic
// assumes the host model drives the acknowledge strobe
`timescale 1ns/100ps
`default_nettype none
module testbench
  import icl_pkg::*;
;
  logic       sys_clk, rstn, ackMode, upIn, eoDrv, oe;
  logic [7:0] pend, vec;
  logic [1:0] mode, sAddr;
  logic [4:0] base;
  logic [31:0] seed = 32'h0D9A94B6;
  wire logic  ackN, eoOut, eoOe, irq, vOe, eoPin;
  wire logic [7:0] vData;
  int fail_count = 0;
  int tests_run = 0;

  // the shared chain pin: whoever enables wins
  assign eoPin = eoOe ? eoOut : eoDrv;

  icl_cascade dut_u (.sys_clk(sys_clk), .rstn(rstn), .groupPending(pend), .cascadeMode(mode),
    .slaveAddr(sAddr), .ackMode(ackMode), .vectorBase(base), .irqAckLine_n(ackN),
    .chainEnableOutIn(eoPin), .chainEnableIn(upIn), .chainEnableOut(eoOut),
    .chainEnableOutOe(eoOe), .irqReq(irq), .vectorData(vData), .vectorOe(vOe));
  icl_host_model host_u (.sys_clk(sys_clk), .vectorOe(vOe), .vectorData(vData), .irqAckLine_n(ackN));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int exp_vec(int b, int p);
    for (int i = 0; i < 8; i++)
      if (p[i])
        return b * 8 + i;
    return -1;
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one served interrupt; pending dropped before the last strobe ends
  task automatic serve(input int acks);
    for (int a = 0; a < acks; a++)
    begin
      host_u.ack_start(oe, vec);
      chk("vectorOe", 8'(1), 8'(oe));
      chk("vectorData", 8'(exp_vec(base, pend)), vec);
      if (a == acks - 1)
        pend = 8'h00;
      host_u.ack_end();
      if (a < acks - 1)
        chk("irqReq held", 8'(1), 8'(irq));
    end
    @(negedge sys_clk);
    chk("irqReq cleared", 8'(0), 8'(irq));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    #(8 * 5000);
    fail_count++;
    conclude();
  end

  initial
  begin
    {rstn, pend, sAddr, ackMode, eoDrv, base} = '0;
    mode = ICL_MODE_DAISY;
    upIn = 1'b1;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int k = 0; k < 6; k++)
    begin
      ackMode = k[0] ? ICL_ACK_TWO : ICL_ACK_ONE;
      pend = 8'(rnd()) | ((k == 5) ? 8'h80 : 8'h00);
      pend = (pend == 8'h00) ? 8'h80 : pend;
      base = 5'(rnd());
      repeat (2) @(negedge sys_clk);
      chk("irqReq", 8'(1), 8'(irq));
      chk("chainOut", 8'(0), 8'(eoOut));
      chk("chainOe", 8'(1), 8'(eoOe));
      serve(k[0] ? 2 : 1);
      chk("chainOut back", 8'(1), 8'(eoOut));
    end
    ackMode = ICL_ACK_ONE;
    pend = 8'h04;
    repeat (2) @(negedge sys_clk);
    upIn = 1'b0;
    #1;
    chk("irq withdrawn", 8'(0), 8'(irq));
    chk("chainOut low", 8'(0), 8'(eoOut));
    host_u.ack_start(oe, vec);
    chk("ack refused", 8'(0), 8'(oe));
    host_u.ack_end();
    upIn = 1'b1;
    repeat (2) @(negedge sys_clk);
    serve(1);
    mode = ICL_MODE_SLAVE;
    for (int a = 0; a < 4; a++)
    begin
      sAddr = 2'(a);
      pend = 8'h10;
      {upIn, eoDrv} = 2'(a ^ 1);
      repeat (2) @(negedge sys_clk);
      chk("slave chainOe", 8'(0), 8'(eoOe));
      host_u.ack_start(oe, vec);
      chk("wrong address", 8'(0), 8'(oe));
      host_u.ack_end();
      {upIn, eoDrv} = 2'(a);
      repeat (2) @(negedge sys_clk);
      serve(1);
    end
    conclude();
  end
endmodule
`default_nettype wire
